// File: core/hsr_pkg.sv
package hsr_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned IDLE_SUSPEND_MS = 3;
  localparam int unsigned IDLE_SUSPEND_CYC = IDLE_SUSPEND_MS * 1000 * CLK_MHZ;
  // resume signaling length driven on the link (our choice)
  localparam int unsigned RESUME_SIG_US = 20;
  localparam int unsigned RESUME_SIG_CYC = RESUME_SIG_US * CLK_MHZ;
  localparam int unsigned CNT_W = 24;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK = 4'h4;
  localparam logic [3:0] ADDR_CTRL = 4'h8;
  localparam logic [3:0] ADDR_PORTCMD = 4'hc;
  // ==========================================================
  // status / mask bit positions
  localparam int unsigned ST_GLB = 0;
  localparam int unsigned ST_RSM = 1;
  localparam int unsigned ST_FWU = 2;
  localparam int unsigned ST_W = 3;
  // control bit positions
  localparam int unsigned CT_RWU = 0;
  // port command codes
  localparam logic [2:0] PCMD_SUSPEND = 3'h1;
  localparam logic [2:0] PCMD_RESUME = 3'h2;
  localparam int unsigned NPORT = 5;
  localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
  // ==========================================================
  // states
  typedef enum logic [4:0] {
    S_RUN = 5'h01,
    S_SUSP = 5'h02,
    S_OFF = 5'h04,
    S_LOCK = 5'h08,
    S_RESUME = 5'h10
  } hsr_state_t;
  // avalon request bundle
  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } hsr_av_req_t;
endpackage

// File: core/hsr_ctrl.sv
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module hsr_ctrl #(
  // upstream idle cycles that count as a suspend request
  parameter int unsigned IDLE_CYC = hsr_pkg::IDLE_SUSPEND_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire hsr_pkg::hsr_av_req_t av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  // upstream link state
  input wire logic up_idle,
  input wire logic up_j_to_k,
  output logic up_resume_drive,
  // downstream ports
  input wire logic [hsr_pkg::NPORT-1:0] dn_event,
  output logic dn_signal_en,
  output logic dn_resume_drive,
  output logic [hsr_pkg::NPORT-1:0] port_suspended,
  output logic [hsr_pkg::NPORT-1:0] port_suspend_change_bit,
  input wire logic [hsr_pkg::NPORT-1:0] port_change_clr,
  // processor and clocking
  input wire logic cpu_halt,
  input wire logic external_irq_a,
  input wire logic external_irq_b,
  input wire logic pll_lock,
  output logic osc_pll_en,
  output logic clk_gate_en,
  output logic irq
);
  // ==========================================================
  // declarations
  hsr_pkg::hsr_state_t state_reg; // power state
  logic [hsr_pkg::CNT_W-1:0] cnt_reg; // idle / resume timer
  logic [hsr_pkg::ST_W-1:0] status_reg; // suspend_resume_status_reg
  logic [hsr_pkg::ST_W-1:0] mask_reg; // interrupt mask
  logic rwu_en_reg; // remote wakeup enable
  logic from_up_reg; // resume came from upstream
  logic from_ext_reg; // wake came from an external irq pin
  logic ack_reg; // bus answer phase
  logic [2:0] port_command_field;
  logic [2:0] port_selector_field;
  // bus handshake and wake terms
  logic wr_ok, ext_irq, remote_ev, resume_done;
  // per-event set strobes for the status flags
  logic [hsr_pkg::ST_W-1:0] set_st;

  // ==========================================================
  // bus decode: one wait cycle then answer
  assign wr_ok = av_req.write && ack_reg;
  assign ext_irq = external_irq_a | external_irq_b;
  // remote wakeup sources: any downstream port or irq pin
  assign remote_ev = (|dn_event) | ext_irq;
  assign resume_done = (state_reg == hsr_pkg::S_RESUME) &&
    (cnt_reg == hsr_pkg::CNT_W'(hsr_pkg::RESUME_SIG_CYC - 1));

  // answer phase toggles on each access
  // second cycle of every access is the answer cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (av_req.read || av_req.write) && !ack_reg;
    end
  end

  // waitrequest high until answer cycle
  // an idle slave keeps waitrequest high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      av_waitrequest <= 1'b1;
    end else begin
      av_waitrequest <= !((av_req.read || av_req.write) && !ack_reg);
    end
  end

  // read data mux
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      av_readdata <= 32'h0000_0000;
    end else if ((av_req.read) && !ack_reg) begin
      // latched on the request cycle, stands through the answer
      case (av_req.address)
        hsr_pkg::ADDR_STATUS: av_readdata <= 32'(status_reg);
        hsr_pkg::ADDR_MASK: av_readdata <= 32'(mask_reg);
        hsr_pkg::ADDR_CTRL: av_readdata <= 32'(rwu_en_reg);
        hsr_pkg::ADDR_PORTCMD: begin
          av_readdata <= {27'h0, port_suspended};
        end
        default: av_readdata <= hsr_pkg::UNMAPPED_RD;
      endcase
    end
  end

  // mask and control registers
  // writes to other offsets leave both untouched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mask_reg <= 3'h0;
      rwu_en_reg <= 1'b0;
    end else if (wr_ok) begin
      if (av_req.address == hsr_pkg::ADDR_MASK) begin
        mask_reg <= av_req.writedata[hsr_pkg::ST_W-1:0];
      end
      if (av_req.address == hsr_pkg::ADDR_CTRL) begin
        rwu_en_reg <= av_req.writedata[hsr_pkg::CT_RWU];
      end
    end
  end

  // port command write fields
  assign port_command_field = av_req.writedata[2:0];
  assign port_selector_field = av_req.writedata[10:8];

  // ==========================================================
  // power state machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= hsr_pkg::S_RUN;
      cnt_reg <= '0;
      from_up_reg <= 1'b0;
      from_ext_reg <= 1'b0;
    end else begin
      case (state_reg)
        hsr_pkg::S_RUN: begin
          // 3 ms idle timer
          // any bus activity restarts the count
          if (!up_idle) begin
            cnt_reg <= '0;
          end else if (cnt_reg ==
              hsr_pkg::CNT_W'(IDLE_CYC - 1)) begin
            cnt_reg <= '0;
            state_reg <= hsr_pkg::S_SUSP;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        hsr_pkg::S_SUSP, hsr_pkg::S_OFF: begin
          // only a wake source or the halt leaves suspend
          // upstream resume wins
          if (up_j_to_k) begin
            from_up_reg <= 1'b1;
            from_ext_reg <= 1'b0;
            state_reg <= hsr_pkg::S_LOCK;
          end else if (remote_ev && rwu_en_reg) begin
            from_up_reg <= 1'b0;
            // remembered: the pin may drop before lock
            from_ext_reg <= ext_irq;
            state_reg <= hsr_pkg::S_LOCK;
          end else if (cpu_halt) begin
            state_reg <= hsr_pkg::S_OFF;
          end
        end
        hsr_pkg::S_LOCK: begin
          if (pll_lock) begin
            cnt_reg <= '0;
            state_reg <= hsr_pkg::S_RESUME;
          end
        end
        hsr_pkg::S_RESUME: begin
          // resume signaling length
          if (resume_done) begin
            cnt_reg <= '0;
            state_reg <= hsr_pkg::S_RUN;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        // an illegal code falls back to run
        default: state_reg <= hsr_pkg::S_RUN;
      endcase
    end
  end

  // ==========================================================
  // link and clock outputs
  // all registered from the power state; up_resume_drive also needs from_up_reg low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dn_signal_en <= 1'b1;
      osc_pll_en <= 1'b1;
      clk_gate_en <= 1'b1;
      up_resume_drive <= 1'b0;
      dn_resume_drive <= 1'b0;
    end else begin
      dn_signal_en <= (state_reg == hsr_pkg::S_RUN);
      osc_pll_en <= (state_reg != hsr_pkg::S_OFF);
      clk_gate_en <= (state_reg == hsr_pkg::S_RUN) ||
        (state_reg == hsr_pkg::S_RESUME) || (state_reg == hsr_pkg::S_SUSP);
      dn_resume_drive <= (state_reg == hsr_pkg::S_RESUME);
      up_resume_drive <= (state_reg == hsr_pkg::S_RESUME) && !from_up_reg;
    end
  end

  // ==========================================================
  // status events; set wins over write-one clear
  always_comb begin
    set_st = '0;
    set_st[hsr_pkg::ST_GLB] = (state_reg == hsr_pkg::S_SUSP) &&
      !dn_signal_en && !status_reg[hsr_pkg::ST_GLB];
    set_st[hsr_pkg::ST_RSM] = (state_reg == hsr_pkg::S_LOCK) && pll_lock;
    set_st[hsr_pkg::ST_FWU] = (state_reg == hsr_pkg::S_LOCK) && pll_lock &&
      from_ext_reg;
  end

  // sticky status register
  // write-one clear; an event in the same cycle still lands
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_reg <= 3'h0;
    end else if (wr_ok && av_req.address == hsr_pkg::ADDR_STATUS) begin
      status_reg <= (status_reg & ~av_req.writedata[hsr_pkg::ST_W-1:0])
        | set_st;
    end else begin
      status_reg <= status_reg | set_st;
    end
  end

  // interrupt follows status one cycle later
  // level interrupt, masked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // ==========================================================
  // per-port suspend and change bits
  genvar gi;
  generate
    for (gi = 0; gi < hsr_pkg::NPORT; gi++) begin : g_port
      // port n is held in bit n-1
      // command to selected port
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          port_suspended[gi] <= 1'b0;
        end else if (wr_ok && av_req.address == hsr_pkg::ADDR_PORTCMD &&
            port_selector_field == 3'(gi + 1)) begin
          // other command codes leave the port as it is
          if (port_command_field == hsr_pkg::PCMD_SUSPEND) begin
            port_suspended[gi] <= 1'b1;
          end else if (port_command_field == hsr_pkg::PCMD_RESUME) begin
            port_suspended[gi] <= 1'b0;
          end
        end
      end
      // change bit at resume end, or on a resume command to a suspended port 1 to 4
      // hardware sets, firmware clears; set wins
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          port_suspend_change_bit[gi] <= 1'b0;
        end else if (resume_done || (wr_ok &&
            av_req.address == hsr_pkg::ADDR_PORTCMD &&
            port_selector_field == 3'(gi + 1) &&
            port_command_field == hsr_pkg::PCMD_RESUME &&
            port_suspended[gi] && gi < 4)) begin
          port_suspend_change_bit[gi] <= 1'b1;
        end else if (port_change_clr[gi]) begin
          port_suspend_change_bit[gi] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: tb/hsr_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// power flow and bus checker
module hsr_ctrl_monitor #(
  // idle cycles that the bound design waits
  parameter int unsigned IDLE_CYC = hsr_pkg::IDLE_SUSPEND_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus
  input wire hsr_pkg::hsr_av_req_t av_req,
  input wire logic av_waitrequest,
  // link and ports
  input wire logic up_idle,
  input wire logic up_resume_drive,
  input wire logic dn_signal_en,
  input wire logic dn_resume_drive,
  input wire logic [hsr_pkg::NPORT-1:0] port_suspend_change_bit,
  // clocking
  input wire logic cpu_halt,
  input wire logic pll_lock,
  input wire logic osc_pll_en,
  input wire logic clk_gate_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // idle run length and resume drive length
  logic [hsr_pkg::CNT_W-1:0] idle_cnt;
  logic [hsr_pkg::CNT_W-1:0] drv_cnt;
  logic drv;
  assign drv = up_resume_drive | dn_resume_drive;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) idle_cnt <= '0;
    else if (!up_idle) idle_cnt <= '0;
    else if (idle_cnt < IDLE_CYC) idle_cnt <= idle_cnt + 1'b1;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) drv_cnt <= '0;
    else drv_cnt <= drv ? drv_cnt + 1'b1 : '0;
  end
  idle_entry_a: assert property ($fell(dn_signal_en) |->
    idle_cnt >= IDLE_CYC - 2) else $error("early suspend");
  halt_off_a: assert property ($fell(osc_pll_en) |->
    $past(cpu_halt) && !dn_signal_en) else $error("osc off without halt");
  gate_lock_a: assert property ($rose(clk_gate_en) |->
    $past(pll_lock) && osc_pll_en) else $error("ungated before lock");
  gate_off_a: assert property (!osc_pll_en && $past(!osc_pll_en) |->
    !clk_gate_en) else $error("clocks run with osc off");
  resume_len_a: assert property ($fell(drv) |-> drv_cnt inside
    {[hsr_pkg::RESUME_SIG_CYC-1:hsr_pkg::RESUME_SIG_CYC+1]})
    else $error("resume length wrong");
  wake_order_a: assert property ($rose(drv) |->
    osc_pll_en && clk_gate_en) else $error("resume before clocks");
  change_set_a: assert property ($fell(drv) |->
    ##[0:2] (&port_suspend_change_bit)) else $error("change bits not set");
  bus_answer_a: assert property ($rose(av_req.read) ||
    $rose(av_req.write) |=> !av_waitrequest ##1 av_waitrequest)
    else $error("bus answer timing");
  cover property ($fell(dn_signal_en));
  cover property ($fell(osc_pll_en));
  cover property ($rose(up_resume_drive));
  cover property ($rose(dn_resume_drive));
endmodule
bind hsr_ctrl hsr_ctrl_monitor #(.IDLE_CYC(IDLE_CYC)) u_hsr_ctrl_monitor (
  .clk(clk), .rst_b(rst_b),
  .av_req(av_req), .av_waitrequest(av_waitrequest), .up_idle(up_idle),
  .up_resume_drive(up_resume_drive), .dn_signal_en(dn_signal_en),
  .dn_resume_drive(dn_resume_drive), .cpu_halt(cpu_halt),
  .port_suspend_change_bit(port_suspend_change_bit), .pll_lock(pll_lock),
  .osc_pll_en(osc_pll_en), .clk_gate_en(clk_gate_en));
`default_nettype wire

// File: tb/hsr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// upstream host and pll model
module hsr_host_model #(
  parameter int LOCK_CYC = 40
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bench commands
  input wire logic go_idle,
  input wire logic go_resume,
  // device side
  input wire logic osc_pll_en,
  output logic up_idle,
  output logic up_j_to_k,
  output logic pll_lock
);
  logic [7:0] lock_cnt; // cycles since osc enable
  // quiet bus, then one J-to-K pulse
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      up_idle <= 1'b0;
      up_j_to_k <= 1'b0;
    end else begin
      up_idle <= go_idle & ~go_resume;
      up_j_to_k <= go_resume;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lock_cnt <= 8'h00;
    else if (!osc_pll_en) lock_cnt <= 8'h00;
    else if (lock_cnt != 8'(LOCK_CYC)) lock_cnt <= lock_cnt + 8'h01;
  end
  assign pll_lock = (lock_cnt == 8'(LOCK_CYC));
endmodule
`default_nettype wire

// File: tb/usb_hub_suspend_resume_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module usb_hub_suspend_resume_ctrl_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  hsr_pkg::hsr_av_req_t av_req = '0;
  logic [31:0] av_readdata, rd;
  logic av_waitrequest, up_idle, up_j_to_k, up_resume_drive, dn_signal_en;
  logic dn_resume_drive, osc_pll_en, clk_gate_en, irq, pll_lock;
  logic [4:0] dn_event = '0, port_change_clr = '0, psusp, pchg;
  logic cpu_halt = 0, ext_a = 0, ext_b = 0, go_idle = 0, go_resume = 0;
  int fail_count = 0, compares = 0, cyc = 0;
  always #2.5 clk = ~clk;
  // short idle count keeps each suspend entry quick
  hsr_ctrl #(.IDLE_CYC(10000)) u_hsr_ctrl (.clk(clk), .rst_b(rst_b),
    .av_req(av_req),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .up_idle(up_idle), .up_j_to_k(up_j_to_k), .dn_event(dn_event),
    .up_resume_drive(up_resume_drive), .dn_signal_en(dn_signal_en),
    .dn_resume_drive(dn_resume_drive), .port_suspended(psusp),
    .port_suspend_change_bit(pchg), .port_change_clr(port_change_clr),
    .cpu_halt(cpu_halt), .external_irq_a(ext_a), .external_irq_b(ext_b),
    .pll_lock(pll_lock), .osc_pll_en(osc_pll_en),
    .clk_gate_en(clk_gate_en), .irq(irq));
  hsr_host_model u_hsr_host_model (.clk(clk), .rst_b(rst_b),
    .go_idle(go_idle), .go_resume(go_resume), .osc_pll_en(osc_pll_en),
    .up_idle(up_idle), .up_j_to_k(up_j_to_k), .pll_lock(pll_lock));
  // ==========================================
  // compare, bus access, closing
  task chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    av_req <= '{a, !wr, wr, d};
    @(posedge clk);
    while (av_waitrequest !== 1'b0) @(posedge clk);
    rd = av_readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
    @(posedge clk);
  endtask
  task clr_chg;
    port_change_clr <= 5'h1f;
    @(posedge clk);
    port_change_clr <= 5'h00;
    repeat (2) @(posedge clk);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, three suspends of about 14000 cycles each
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // reset reads, unmapped holes included
    for (int i = 0; i < 16; i += 2) begin
      bus(0, 4'(i), '0);
      chk("reset read", '0, rd);
    end
    $display("test reset done");
    // suspend every port, resume port 2, then port 5
    for (int p = 1; p <= 5; p++) bus(1, 4'hc, (p << 8) | 1);
    chk("suspended", 32'h1f, 32'(psusp));
    bus(1, 4'hc, 32'h0202);
    chk("suspended", 32'h1d, 32'(psusp));
    while (pchg[1] !== 1'b1) @(posedge clk);
    chk("port change", 32'h2, 32'(pchg));
    clr_chg;
    bus(1, 4'hc, 32'h0502);
    chk("suspended", 32'h0d, 32'(psusp));
    chk("port 5 change", 32'h0, 32'(pchg));
    $display("test ports done");
    // global suspend then host resume
    bus(1, 4'h4, 32'h7);
    go_idle <= 1'b1;
    while (dn_signal_en !== 1'b0) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("irq", 1, irq);
    bus(0, 4'h0, '0);
    chk("status", 32'h1, rd);
    dn_event <= 5'h04;
    repeat (20) @(posedge clk);
    dn_event <= 5'h00;
    chk("up drive", 0, up_resume_drive);
    cpu_halt <= 1'b1;
    while (osc_pll_en !== 1'b0) @(posedge clk);
    chk("gate", 0, clk_gate_en);
    go_resume <= 1'b1;
    go_idle <= 1'b0;
    @(posedge clk);
    go_resume <= 1'b0;
    while (osc_pll_en !== 1'b1) @(posedge clk);
    cpu_halt <= 1'b0;
    while (dn_resume_drive !== 1'b1) @(posedge clk);
    chk("up drive", 0, up_resume_drive);
    chk("wake irq", 1, irq);
    while (dn_resume_drive !== 1'b0) @(posedge clk);
    repeat (3) @(posedge clk);
    chk("all change", 32'h1f, 32'(pchg));
    bus(0, 4'h0, '0);
    chk("status", 32'h3, rd);
    bus(1, 4'h4, '0);
    repeat (2) @(posedge clk);
    chk("masked irq", 0, irq);
    bus(1, 4'h0, 32'h3);
    bus(0, 4'h0, '0);
    chk("status", 0, rd);
    bus(1, 4'h4, 32'h7);
    clr_chg;
    $display("test global resume done");
    // remote wakeup from external irq
    bus(1, 4'h8, 32'h1);
    go_idle <= 1'b1;
    while (dn_signal_en !== 1'b0) @(posedge clk);
    cpu_halt <= 1'b1;
    while (osc_pll_en !== 1'b0) @(posedge clk);
    ext_a <= 1'b1;
    while (osc_pll_en !== 1'b1) @(posedge clk);
    cpu_halt <= 1'b0;
    ext_a <= 1'b0;
    while (up_resume_drive !== 1'b1) @(posedge clk);
    go_idle <= 1'b0;
    chk("dn drive", 1, dn_resume_drive);
    while (up_resume_drive !== 1'b0) @(posedge clk);
    bus(0, 4'h0, '0);
    chk("status", 32'h7, rd);
    bus(1, 4'h0, 32'h7);
    bus(0, 4'h0, '0);
    chk("status", 0, rd);
    $display("test remote wakeup done");
    // remote wakeup from a downstream port event
    go_idle <= 1'b1;
    while (dn_signal_en !== 1'b0) @(posedge clk);
    dn_event <= 5'h08;
    while (up_resume_drive !== 1'b1) @(posedge clk);
    go_idle <= 1'b0;
    dn_event <= 5'h00;
    while (up_resume_drive !== 1'b0) @(posedge clk);
    bus(0, 4'h0, '0);
    chk("status", 32'h3, rd);
    $display("test port wakeup done");
    wrap_up;
  end
endmodule
`default_nettype wire
